//--- shared/mis_pkg.sv
// How it works
// - OR immediate into working register, store it, zero flag follows the result
// - SFR page read copies addressed register 5..15 into working register, flags kept
// - SFR page write stores working register into page register 0..15, flags kept
// - Long call pushes next address on return stack, loads 10-bit target
// - Long branch loads 10-bit target, no push, no flag change
// - Load immediate puts 8-bit operand in working register, flags kept
`default_nettype none
package mis_pkg;
    localparam int INSTR_W = 14;
    localparam int PC_W    = 10;
    localparam int DATA_W  = 8;
    localparam int SFR_AW  = 4;
    localparam int SFR_NUM = 16;

    localparam logic [SFR_AW-1:0] SFR_READ_MIN = 4'h5;
    localparam logic [PC_W-1:0]   PC_RESET     = 10'h000;
    localparam logic [DATA_W-1:0] ACC_RESET    = 8'h00;
    localparam logic [DATA_W-1:0] SFR_RESET    = 8'h00;

    // Opcode fields: [13:10] for jumps, [13:8] for immediates, [13:4] for SFR ops
    localparam logic [3:0] OPC_LONG_CALL   = 4'hC;
    localparam logic [3:0] OPC_LONG_BRANCH = 4'hD;
    localparam logic [5:0] OPC_LOAD_IMM    = 6'h04;
    localparam logic [5:0] OPC_OR_IMM      = 6'h05;
    localparam logic [9:0] OPC_SFR_READ    = 10'h003;
    localparam logic [9:0] OPC_SFR_WRITE   = 10'h002;

    typedef enum logic [2:0] {
        MIS_OP_NONE      = 3'b000,
        MIS_OP_OR_IMM    = 3'b001,
        MIS_OP_LOAD_IMM  = 3'b010,
        MIS_OP_SFR_READ  = 3'b011,
        MIS_OP_SFR_WRITE = 3'b100,
        MIS_OP_CALL      = 3'b101,
        MIS_OP_BRANCH    = 3'b110
    } mis_op_t;
endpackage
`default_nettype wire

//--- shared/mis_sfr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mis_sfr_if;
    import mis_pkg::*;
    logic                 wr_en;
    logic [SFR_AW-1:0]    addr;
    logic [DATA_W-1:0]    wdata;
    logic [DATA_W-1:0]    rdata;

    modport exec (output wr_en, output addr, output wdata, input rdata);
    modport page (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- rtl/mis_sfr_page.sv
`timescale 1ns/1ps
`default_nettype none
module mis_sfr_page
    import mis_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    mis_sfr_if.page   sfr
);
    typedef struct packed {
        logic [SFR_NUM-1:0][DATA_W-1:0] regs;
    } mis_page_t;

    mis_page_t page_reg;
    mis_page_t page_next;

    // =====================================================
    // Write port
    // =====================================================
    always_comb begin
        page_next = page_reg;
        if (sfr.wr_en) begin
            page_next.regs[sfr.addr] = sfr.wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            page_reg <= '{regs: {SFR_NUM{SFR_RESET}}};
        end else begin
            page_reg <= page_next;
        end
    end

    // =====================================================
    // Read port
    // =====================================================
    // low addresses read zero
    assign sfr.rdata = (sfr.addr >= SFR_READ_MIN) ? page_reg.regs[sfr.addr] : 8'h00;

    a_sfr_write_lands: assert property (@(posedge clk) disable iff (!nrst)
        sfr.wr_en |=> page_reg.regs[$past(sfr.addr)] == $past(sfr.wdata))
        else $error("SFR page write lost");
endmodule // mis_sfr_page
`default_nettype wire

//--- rtl/mis_exec.sv
`timescale 1ns/1ps
`default_nettype none
module mis_exec
    import mis_pkg::*;
#(
    parameter int STACK_DEPTH = 8
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic [INSTR_W-1:0] pmem_data,
    output logic      [PC_W-1:0]    pmem_addr,
    output logic      [DATA_W-1:0]  working_register,
    output logic                    zero_flag,
    output logic      [PC_W-1:0]    program_counter,
    output logic      [$clog2(STACK_DEPTH)-1:0] stack_level
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    // =====================================================
    // Parameter check
    // =====================================================
    generate
        if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_bad_depth
            $error("STACK_DEPTH must be a power of two, at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [PC_W-1:0]                   pc;
        logic [PC_W-1:0]                   exec_pc;
        logic                              fetch_valid;
        logic [DATA_W-1:0]                 acc;
        logic                              zflag;
        logic [SP_W-1:0]                   sp;
        logic [STACK_DEPTH-1:0][PC_W-1:0]  stack;
    } mis_state_t;

    mis_state_t state_reg;
    mis_state_t state_next;

    mis_sfr_if sfr ();

    mis_sfr_page u_sfr_page (
        .clk  (clk),
        .nrst (nrst),
        .sfr  (sfr.page)
    );

    // =====================================================
    // Decode
    // =====================================================
    function automatic mis_op_t decode_op(input logic [INSTR_W-1:0] ins);
        mis_op_t op;
        op = MIS_OP_NONE;
        if (ins[13:10] == OPC_LONG_CALL) begin
            op = MIS_OP_CALL;
        end else if (ins[13:10] == OPC_LONG_BRANCH) begin
            op = MIS_OP_BRANCH;
        end else if (ins[13:8] == OPC_OR_IMM) begin
            op = MIS_OP_OR_IMM;
        end else if (ins[13:8] == OPC_LOAD_IMM) begin
            op = MIS_OP_LOAD_IMM;
        end else if (ins[13:4] == OPC_SFR_READ) begin
            op = MIS_OP_SFR_READ;
        end else if (ins[13:4] == OPC_SFR_WRITE) begin
            op = MIS_OP_SFR_WRITE;
        end
        return op;
    endfunction

    mis_op_t            op;
    logic [DATA_W-1:0]  imm;
    logic [PC_W-1:0]    target;
    logic [DATA_W-1:0]  or_result;

    // Fetched word is discarded while a jump refills the pipe
    assign op        = state_reg.fetch_valid ? decode_op(pmem_data) : MIS_OP_NONE;
    assign imm       = pmem_data[DATA_W-1:0];
    assign target    = pmem_data[PC_W-1:0];
    assign or_result = state_reg.acc | imm;

    assign sfr.addr  = pmem_data[SFR_AW-1:0];
    assign sfr.wdata = state_reg.acc;
    assign sfr.wr_en = (op == MIS_OP_SFR_WRITE);

    // =====================================================
    // Execute
    // =====================================================
    always_comb begin
        state_next             = state_reg;
        state_next.pc          = state_reg.pc + 10'h001;
        state_next.exec_pc     = state_reg.pc;
        state_next.fetch_valid = 1'b1;
        case (op)
            MIS_OP_OR_IMM: begin
                state_next.acc   = or_result;
                state_next.zflag = (or_result == 8'h00);
            end
            MIS_OP_LOAD_IMM: begin
                state_next.acc = imm;
            end
            MIS_OP_SFR_READ: begin
                state_next.acc = sfr.rdata;
            end
            MIS_OP_CALL: begin
                state_next.stack[state_reg.sp] = state_reg.exec_pc + 10'h001;
                state_next.sp                  = state_reg.sp + 1'b1;
                state_next.pc                  = target;
                state_next.fetch_valid         = 1'b0;
            end
            MIS_OP_BRANCH: begin
                state_next.pc          = target;
                state_next.fetch_valid = 1'b0;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '{pc: PC_RESET, exec_pc: PC_RESET, fetch_valid: 1'b0,
                           acc: ACC_RESET, zflag: 1'b0, sp: '0,
                           stack: {STACK_DEPTH{PC_RESET}}};
        end else begin
            state_reg <= state_next;
        end
    end

    assign pmem_addr        = state_reg.pc;
    assign working_register = state_reg.acc;
    assign zero_flag        = state_reg.zflag;
    assign program_counter  = state_reg.exec_pc;
    assign stack_level      = state_reg.sp;

    // =====================================================
    // Checks
    // =====================================================
    sequence s_jump_taken;
        op == MIS_OP_CALL || op == MIS_OP_BRANCH;
    endsequence

    sequence s_refill;
        !state_reg.fetch_valid ##1 state_reg.fetch_valid;
    endsequence

    sequence s_single_op;
        op == MIS_OP_OR_IMM || op == MIS_OP_LOAD_IMM ||
        op == MIS_OP_SFR_READ || op == MIS_OP_SFR_WRITE;
    endsequence

    a_or_imm_result: assert property (@(posedge clk) disable iff (!nrst)
        op == MIS_OP_OR_IMM |=> state_reg.acc == ($past(state_reg.acc) | $past(imm))
            && state_reg.zflag == ((($past(state_reg.acc) | $past(imm))) == 8'h00))
        else $error("OR immediate result or zero flag wrong");

    a_sfr_read_copy: assert property (@(posedge clk) disable iff (!nrst)
        op == MIS_OP_SFR_READ |=> state_reg.acc == $past(sfr.rdata) && $stable(state_reg.zflag))
        else $error("SFR page read did not copy");

    a_sfr_write_keep: assert property (@(posedge clk) disable iff (!nrst)
        op == MIS_OP_SFR_WRITE |-> sfr.wr_en && sfr.wdata == state_reg.acc
            ##1 $stable(state_reg.zflag) && $stable(state_reg.acc))
        else $error("SFR page write strobe or flags wrong");

    a_call_push_pc: assert property (@(posedge clk) disable iff (!nrst)
        op == MIS_OP_CALL |=> state_reg.pc == $past(target)
            && state_reg.stack[$past(state_reg.sp)] == $past(state_reg.exec_pc) + 10'h001
            && state_reg.sp == $past(state_reg.sp) + 1'b1)
        else $error("Long call push or target wrong");

    a_branch_no_push: assert property (@(posedge clk) disable iff (!nrst)
        op == MIS_OP_BRANCH |=> state_reg.pc == $past(target) && $stable(state_reg.sp)
            && $stable(state_reg.zflag))
        else $error("Long branch wrong");

    a_load_imm_flags: assert property (@(posedge clk) disable iff (!nrst)
        op == MIS_OP_LOAD_IMM |=> state_reg.acc == $past(imm) && $stable(state_reg.zflag))
        else $error("Load immediate wrong");

    a_jump_two_cycle: assert property (@(posedge clk) disable iff (!nrst)
        s_jump_taken |=> s_refill)
        else $error("Jump did not take two cycles");

    a_single_cycle_op: assert property (@(posedge clk) disable iff (!nrst)
        s_single_op |=> state_reg.fetch_valid && state_reg.exec_pc == $past(state_reg.pc))
        else $error("Single-cycle op stalled");

    a_discard_inert: assert property (@(posedge clk) disable iff (!nrst)
        !state_reg.fetch_valid |=> $stable(state_reg.acc) && $stable(state_reg.zflag)
            && $stable(state_reg.sp))
        else $error("Discarded word changed state");

    a_nop_advance: assert property (@(posedge clk) disable iff (!nrst)
        state_reg.fetch_valid && op == MIS_OP_NONE
            |=> state_reg.pc == $past(state_reg.pc) + 10'h001 && $stable(state_reg.acc)
            && $stable(state_reg.zflag) && $stable(state_reg.sp))
        else $error("Unknown word did not act as no-op");

    a_stack_call_only: assert property (@(posedge clk) disable iff (!nrst)
        op != MIS_OP_CALL |=> $stable(state_reg.sp))
        else $error("Stack level moved without a call");

    a_call_target_exec: assert property (@(posedge clk) disable iff (!nrst)
        op == MIS_OP_CALL |=> ##1 state_reg.fetch_valid
            && state_reg.exec_pc == $past(target, 2))
        else $error("Call target not executed after refill");
endmodule // mis_exec
`default_nettype wire

//--- tb/mis_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module mis_exec_tb_top;
    import mis_pkg::*;
    logic               clk;
    logic               nrst;
    logic [INSTR_W-1:0] pmem_data;
    logic [PC_W-1:0]    pmem_addr;
    logic [DATA_W-1:0]  working_register;
    logic               zero_flag;
    logic [PC_W-1:0]    program_counter;
    logic [2:0]         stack_level;
    logic [INSTR_W-1:0] rom [0:1023];
    int                 err_total;
    int                 samples_checked;

    mis_exec #(.STACK_DEPTH(8)) u_mis_exec (
        .clk(clk), .nrst(nrst), .pmem_data(pmem_data), .pmem_addr(pmem_addr),
        .working_register(working_register), .zero_flag(zero_flag),
        .program_counter(program_counter), .stack_level(stack_level)
    );

    // ==========================================
    // Clock and one-cycle program memory
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        pmem_data <= rom[pmem_addr];
    end

    function automatic logic [13:0] op_imm(input logic [5:0] o, input logic [7:0] v);
        return {o, v};
    endfunction
    function automatic logic [13:0] op_jmp(input logic [3:0] o, input logic [9:0] t);
        return {o, t};
    endfunction
    function automatic logic [13:0] op_sfr(input logic [9:0] o, input logic [3:0] a);
        return {o, a};
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic clear_rom;
        for (int i = 0; i < 1024; i++) rom[i] = 14'h0000;
    endtask
    task automatic do_reset;
        @(posedge clk);
        nrst <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        `CHK("reset acc", 8'h00, working_register)
        `CHK("reset zero", 1'b0, zero_flag)
        `CHK("reset level", 3'h0, stack_level)
        `CHK("reset fetch", 10'h000, pmem_addr)
        `CHK("reset pc", 10'h000, program_counter)
        @(posedge clk);
        nrst <= 1'b1;
    endtask

    // ==========================================
    // Scenarios
    // immediate ops
    task automatic t_imm;
        logic [7:0] ea [5];
        logic       ez [5];
        ea = '{8'h00, 8'h00, 8'hAA, 8'hFA, 8'h00};
        ez = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        clear_rom();
        rom[0] = op_imm(OPC_LOAD_IMM, 8'h00);
        rom[1] = op_imm(OPC_OR_IMM, 8'h00);
        rom[2] = op_imm(OPC_LOAD_IMM, 8'hAA);
        rom[3] = op_imm(OPC_OR_IMM, 8'h50);
        rom[4] = op_imm(OPC_LOAD_IMM, 8'h00);
        do_reset();
        step(1);
        for (int i = 0; i < 5; i++) begin
            step(1);
            `CHK("imm acc", ea[i], working_register)
            `CHK("imm zero", ez[i], zero_flag)
            `CHK("imm fetch", 10'(i + 2), pmem_addr)
            `CHK("imm pc", 10'(i + 1), program_counter)
        end
        step(2);
        `CHK("nop acc", 8'h00, working_register)
        `CHK("nop zero", 1'b0, zero_flag)
        `CHK("nop fetch", 10'h008, pmem_addr)
        $display("test imm done");
    endtask

    task automatic t_sfr;
        logic [7:0] ev;
        clear_rom();
        rom[0] = op_imm(OPC_LOAD_IMM, 8'h00);
        rom[1] = op_imm(OPC_OR_IMM, 8'h00);
        for (int a = 0; a < 16; a++) begin
            rom[2 + 4 * a] = op_imm(OPC_LOAD_IMM, 8'hA0 + 8'(a));
            rom[3 + 4 * a] = op_sfr(OPC_SFR_WRITE, 4'(a));
            rom[4 + 4 * a] = op_imm(OPC_LOAD_IMM, 8'hFF);
            rom[5 + 4 * a] = op_sfr(OPC_SFR_READ, 4'(a));
            rom[66 + a] = op_sfr(OPC_SFR_READ, 4'(a));
        end
        do_reset();
        step(3);
        for (int a = 0; a < 16; a++) begin
            step(4);
            ev = (a >= 5) ? 8'hA0 + 8'(a) : 8'h00;
            `CHK("sfr acc", ev, working_register)
            `CHK("sfr zero", 1'b1, zero_flag)
        end
        for (int a = 0; a < 16; a++) begin
            step(1);
            ev = (a >= 5) ? 8'hA0 + 8'(a) : 8'h00;
            `CHK("sfr reread", ev, working_register)
        end
        $display("test sfr done");
    endtask

    task automatic t_jump;
        clear_rom();
        rom[0] = op_imm(OPC_OR_IMM, 8'h00);
        rom[1] = op_jmp(OPC_LONG_CALL, 10'h100);
        rom[2] = op_imm(OPC_LOAD_IMM, 8'hEE);
        rom[10'h100] = op_imm(OPC_LOAD_IMM, 8'h02);
        rom[10'h101] = op_jmp(OPC_LONG_BRANCH, 10'h3FF);
        rom[10'h102] = op_imm(OPC_LOAD_IMM, 8'hEE);
        rom[10'h3FF] = op_jmp(OPC_LONG_BRANCH, 10'h200);
        rom[10'h200] = op_imm(OPC_LOAD_IMM, 8'h03);
        rom[10'h201] = op_jmp(OPC_LONG_BRANCH, 10'h201);
        do_reset();
        step(3);
        `CHK("call level", 3'h1, stack_level)
        `CHK("call fetch", 10'h100, pmem_addr)
        step(1);
        `CHK("call discard", 8'h00, working_register)
        step(1);
        `CHK("call target", 8'h02, working_register)
        `CHK("call pc", 10'h101, program_counter)
        step(1);
        `CHK("branch fetch", 10'h3FF, pmem_addr)
        `CHK("branch level", 3'h1, stack_level)
        step(1);
        `CHK("branch discard", 8'h02, working_register)
        step(1);
        `CHK("branch top", 10'h200, pmem_addr)
        step(2);
        `CHK("branch acc", 8'h03, working_register)
        `CHK("branch zero", 1'b1, zero_flag)
        `CHK("branch pc", 10'h201, program_counter)
        $display("test jump done");
    endtask

    task automatic t_wrap;
        clear_rom();
        for (int i = 0; i < 9; i++) rom[16 * i] = op_jmp(OPC_LONG_CALL, 10'(16 * (i + 1)));
        do_reset();
        for (int i = 0; i < 9; i++) begin
            step(2);
            `CHK("nest level", 3'(i + 1), stack_level)
            `CHK("nest fetch", 10'(16 * (i + 1)), pmem_addr)
        end
        $display("test wrap done");
    endtask

    // ==========================================
    // Verdict, watchdog and main sequence
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        results();
    end
    initial begin
        nrst = 1'b0;
        err_total = 0;
        samples_checked = 0;
        clear_rom();
        t_imm();
        t_sfr();
        t_jump();
        t_wrap();
        results();
    end
endmodule // mis_exec_tb_top
`default_nettype wire
